//--- bsf_pkg.sv
// Shared constants for the two-wire bus status and event-flag block
package bsf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL     = 10'h0f0;
  localparam logic [9:0] IDX_STATUS_ONE  = 10'h0f1;
  localparam logic [9:0] IDX_STATUS_TWO  = 10'h0f2;
  localparam logic [9:0] IDX_CLOCK_SETUP = 10'h0f3;
  localparam logic [9:0] IDX_DATA        = 10'h0f6;
  localparam logic [9:0] IDX_EXT_SETUP   = 10'h0f8;
  localparam int         ADDR_W          = 12;

  // Control register fields
  localparam int CTL_PERIPHERAL_ON   = 5;
  localparam int CTL_BROADCAST_EN    = 4;
  localparam int CTL_START           = 3;
  localparam int CTL_ACK_EN          = 2;
  localparam int CTL_STOP            = 1;
  localparam int CTL_INTERRUPT_ALLOW = 0;

  // Status one fields
  localparam int S1_EVENT_PENDING  = 7;
  localparam int S1_HEADER_SENT    = 6;
  localparam int S1_DIRECTION_TX   = 5;
  localparam int S1_BUS_BUSY       = 4;
  localparam int S1_BYTE_DONE      = 3;
  localparam int S1_OWN_ADDR_HIT   = 2;
  localparam int S1_MASTER_ACTIVE  = 1;
  localparam int S1_START_SENT     = 0;

  // Status two fields
  localparam int S2_ADDRESS_ACKED  = 5;
  localparam int S2_ACK_MISSING    = 4;
  localparam int S2_STOP_SEEN      = 3;
  localparam int S2_ARB_LOST       = 2;
  localparam int S2_MISPLACED      = 1;
  localparam int S2_BROADCAST_HIT  = 0;

  // Clock setup and extension fields
  localparam int CLK_FAST_SELECT   = 7;
  localparam int EXT_TEN_BIT_MODE  = 2;

  // Reset values, and the control bits kept while switched off
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] CLOCK_SETUP_RESET = 8'h00;
  localparam logic [7:0] EXT_SETUP_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET        = 8'h00;
  localparam logic [7:0] STOP_KEEP_MASK    = 8'h02;

  // Divider timing: period = mult * (divider + offset) system clocks
  localparam logic [1:0] STD_MULT   = 2'h2;
  localparam logic [1:0] FAST_MULT  = 2'h3;
  localparam logic [9:0] DIV_OFFSET = 10'h002;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bsf_pkg

//--- bsf_flags.sv
// Status, event flags, clock stretch and divider of the two-wire bus interface
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module bsf_flags
  import bsf_pkg::*;
(
  // Clock and reset
  input  wire logic                       CORE_CLK,
  input  wire logic                       RST,
  // AXI4-Lite write channels
  input  wire logic [bsf_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output var  logic                       S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output var  logic                       S_AXI_WREADY,
  output var  logic [1:0]                 S_AXI_BRESP,
  output var  logic                       S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire logic [bsf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output var  logic                       S_AXI_ARREADY,
  output var  logic [31:0]                S_AXI_RDATA,
  output var  logic [1:0]                 S_AXI_RRESP,
  output var  logic                       S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  // Sampled bus lines
  input  wire logic                       SCL_IN,
  input  wire logic                       SDA_IN,
  // Events from the shift engine, one-cycle pulses
  input  wire logic                       EV_START_DONE,
  input  wire logic                       EV_HEADER_SENT,
  input  wire logic                       EV_TX_ACK_PULSE,
  input  wire logic                       EV_RX_ACK_PULSE,
  input  wire logic                       EV_OWN_MATCH,
  input  wire logic                       EV_BROADCAST_MATCH,
  input  wire logic                       EV_ADDR_ACKED,
  input  wire logic                       EV_NO_ACK,
  input  wire logic                       EV_ARB_LOST,
  // Engine levels and received byte
  input  wire logic                       IN_BYTE,
  input  wire logic                       ACK_PULSE,
  input  wire logic [7:0]                 RX_DATA,
  // DMA status
  input  wire logic                       DMA_BUSY,
  input  wire logic                       DMA_DONE,
  // Outputs to the engine and the core
  output var  logic                       GEN_START,
  output var  logic                       GEN_STOP,
  output var  logic                       SCL_HOLD_LOW,
  output var  logic                       SCL_TICK,
  output var  logic [7:0]                 TX_DATA,
  output var  logic                       IRQ
);
  import bsf_pkg::*;

  // Word index match, low address bits ignored
  function automatic logic idx_is(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    return a[ADDR_W-1:2] == idx;
  endfunction : idx_is

  // Bus clock period in system clocks
  function automatic logic [10:0] scl_period(input logic fast, input logic [8:0] div);
    logic [10:0] base;
    base = {2'h0, div} + {1'b0, DIV_OFFSET};
    return fast ? 11'(base * FAST_MULT) : 11'(base * STD_MULT);
  endfunction : scl_period

  // Bus slave state
  logic                aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0]   awaddr_q, awaddr_d;
  logic [7:0]          wbyte_q, wbyte_d;
  logic                wlane_q, wlane_d;
  logic                awready_q, awready_d, wready_q, wready_d;
  logic                bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]         rdata_q, rdata_d;
  // Registers and flags
  logic [7:0]          ctrl_q, ctrl_d, clk_q, clk_d, ext_q, ext_d, data_q, data_d;
  logic [7:0]          s1_q, s1_d, s2_q, s2_d;
  logic                sr1_seen_q, sr1_seen_d, saw_ack_q, saw_ack_d;
  logic                scl_prev_q, sda_prev_q;
  logic                gen_start_q, gen_start_d, gen_stop_q, gen_stop_d;
  logic                hold_q, hold_d, tick_q, tick_d, irq_q, irq_d;
  logic [10:0]         cnt_q, cnt_d;
  // Decoded strobes and events
  logic do_write, do_read, wr_en, wr_ctrl, wr_clk, wr_ext, wr_data;
  logic rd_sr1, rd_sr2, rd_data, pe, master, start_det, stop_det;
  logic set_start, set_header, set_bd, set_own, set_acked, set_af;
  logic set_stop_seen, set_arbitration_lost, set_misplaced_condition_error, set_broadcast_hit, bd_clr, irq_hit;

  // Write address and data may arrive in either order
  always_comb
  begin
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (S_AXI_AWVALID && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wready_q)
    begin
      w_have_d = 1'b1;
      wbyte_d  = S_AXI_WDATA[7:0];
      wlane_d  = S_AXI_WSTRB[0];
    end
    do_write = aw_have_q && w_have_q && !bvalid_q;
    if (bvalid_q && S_AXI_BREADY)
      bvalid_d = 1'b0;
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (idx_is(awaddr_q, IDX_CONTROL) || idx_is(awaddr_q, IDX_CLOCK_SETUP) ||
                   idx_is(awaddr_q, IDX_EXT_SETUP) || idx_is(awaddr_q, IDX_DATA) ||
                   idx_is(awaddr_q, IDX_STATUS_ONE) || idx_is(awaddr_q, IDX_STATUS_TWO))
                  ? RESP_OKAY : RESP_SLVERR;
    end
    // Ready is a flop, so it drops one cycle after a channel is taken
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    wr_en     = do_write && wlane_q;
    wr_ctrl   = wr_en && idx_is(awaddr_q, IDX_CONTROL);
    wr_clk    = wr_en && idx_is(awaddr_q, IDX_CLOCK_SETUP);
    wr_ext    = wr_en && idx_is(awaddr_q, IDX_EXT_SETUP);
    wr_data   = wr_en && idx_is(awaddr_q, IDX_DATA);
  end

  // Read channel; side effects of a read happen at acceptance
  always_comb
  begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    do_read   = S_AXI_ARVALID && arready_q;
    rd_sr1    = do_read && idx_is(S_AXI_ARADDR, IDX_STATUS_ONE);
    rd_sr2    = do_read && idx_is(S_AXI_ARADDR, IDX_STATUS_TWO);
    rd_data   = do_read && idx_is(S_AXI_ARADDR, IDX_DATA);
    if (rvalid_q && S_AXI_RREADY)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    if (do_read)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = RESP_OKAY;
      rdata_d   = 32'h0;
      // Held value plus any racing set, so the clearing read still shows it
      if (idx_is(S_AXI_ARADDR, IDX_CONTROL))          rdata_d[7:0] = {2'h0, ctrl_q[5:0]};
      else if (rd_sr1)                                 rdata_d[7:0] = s1_q | s1_d;
      else if (rd_sr2)                                 rdata_d[7:0] = {2'h0, s2_q[5:0] | s2_d[5:0]};
      else if (idx_is(S_AXI_ARADDR, IDX_CLOCK_SETUP)) rdata_d[7:0] = clk_q;
      else if (idx_is(S_AXI_ARADDR, IDX_EXT_SETUP))   rdata_d[7:0] = ext_q;
      else if (rd_data)                                rdata_d[7:0] = data_q;
      else                                             rresp_d = RESP_SLVERR;
    end
  end

  // Bus conditions and flag next values
  always_comb
  begin
    pe        = ctrl_q[CTL_PERIPHERAL_ON];
    master    = s1_q[S1_MASTER_ACTIVE];
    start_det = SCL_IN && scl_prev_q && sda_prev_q && !SDA_IN;
    stop_det  = SCL_IN && scl_prev_q && !sda_prev_q && SDA_IN;
    set_start  = EV_START_DONE;
    set_header = EV_HEADER_SENT && master && ext_q[EXT_TEN_BIT_MODE];
    set_bd     = EV_TX_ACK_PULSE || (EV_RX_ACK_PULSE && ctrl_q[CTL_ACK_EN]);
    set_own    = (EV_OWN_MATCH || (EV_BROADCAST_MATCH && ctrl_q[CTL_BROADCAST_EN]))
                 && !master;
    set_acked  = EV_ADDR_ACKED && master;
    set_misplaced_condition_error   = (start_det || stop_det) && IN_BYTE;
    set_af     = EV_NO_ACK || (stop_det && IN_BYTE && ACK_PULSE);
    set_arbitration_lost   = (EV_ARB_LOST && master) || (start_det && IN_BYTE);
    set_stop_seen  = stop_det && !master && saw_ack_q;
    set_broadcast_hit   = EV_BROADCAST_MATCH && ctrl_q[CTL_BROADCAST_EN];
    // Transmit byte-done clears on data write, receive on data read
    bd_clr = DMA_DONE || (sr1_seen_q && (s1_q[S1_DIRECTION_TX] ? wr_data : rd_data));
    sr1_seen_d = rd_sr1 || (sr1_seen_q && !wr_data && !rd_data);
    saw_ack_d  = EV_TX_ACK_PULSE || EV_RX_ACK_PULSE || EV_ADDR_ACKED ||
                 (saw_ack_q && !start_det && !stop_det);
    // Set always wins over a clear in the same cycle
    s1_d = 8'h00;
    s1_d[S1_BUS_BUSY]      = start_det || (s1_q[S1_BUS_BUSY] && !stop_det);
    s1_d[S1_START_SENT]    = pe && (set_start ||
                             (s1_q[S1_START_SENT] && !(sr1_seen_q && wr_data)));
    s1_d[S1_HEADER_SENT]   = pe && (set_header || (s1_q[S1_HEADER_SENT] &&
                             !(sr1_seen_q && wr_data) && !set_stop_seen));
    s1_d[S1_BYTE_DONE]     = pe && (set_bd || (s1_q[S1_BYTE_DONE] && !bd_clr));
    s1_d[S1_DIRECTION_TX]  = pe && (EV_TX_ACK_PULSE || (s1_q[S1_DIRECTION_TX] &&
                             s1_d[S1_BYTE_DONE] && !EV_RX_ACK_PULSE && !set_stop_seen &&
                             !set_arbitration_lost));
    s1_d[S1_OWN_ADDR_HIT]  = pe && (set_own || (s1_q[S1_OWN_ADDR_HIT] && !rd_sr1));
    s1_d[S1_MASTER_ACTIVE] = pe && (set_start ||
                             (master && !stop_det && !set_arbitration_lost));
    s2_d = 8'h00;
    s2_d[S2_ADDRESS_ACKED] = pe && (set_acked || (s2_q[S2_ADDRESS_ACKED] && !rd_sr2));
    s2_d[S2_ACK_MISSING]   = pe && (set_af ||
                             (s2_q[S2_ACK_MISSING] && !(rd_sr2 && !ACK_PULSE)));
    s2_d[S2_STOP_SEEN]     = pe && (set_stop_seen || (s2_q[S2_STOP_SEEN] && !rd_sr2));
    s2_d[S2_ARB_LOST]      = pe && (set_arbitration_lost || (s2_q[S2_ARB_LOST] && !rd_sr2));
    s2_d[S2_MISPLACED]     = pe && (set_misplaced_condition_error || (s2_q[S2_MISPLACED] && !rd_sr2));
    s2_d[S2_BROADCAST_HIT] = pe && (set_broadcast_hit || (s2_q[S2_BROADCAST_HIT] && !stop_det));
    // Summary stays up until every source has gone
    s1_d[S1_EVENT_PENDING] = pe && (s1_d[S1_HEADER_SENT] || s1_d[S1_BYTE_DONE] ||
                             s1_d[S1_OWN_ADDR_HIT] || s1_d[S1_START_SENT] ||
                             (|s2_d[5:1]));
    // A set racing its own clearing read flags the bit but stays quiet
    irq_hit = set_header || set_start || (set_own && !rd_sr1) ||
              ((set_af || set_stop_seen || set_arbitration_lost || set_misplaced_condition_error) && !rd_sr2);
    irq_d   = pe && ctrl_q[CTL_INTERRUPT_ALLOW] && irq_hit;
    hold_d  = pe && (s1_d[S1_BYTE_DONE] || s1_d[S1_OWN_ADDR_HIT] || s1_d[S1_START_SENT] ||
              s1_d[S1_HEADER_SENT] || s2_d[S2_ADDRESS_ACKED] || DMA_BUSY);
  end

  // Control, setup and data registers
  always_comb
  begin
    ctrl_d = ctrl_q;
    clk_d  = clk_q;
    ext_d  = ext_q;
    data_d = data_q;
    // First write after disable only turns the peripheral on
    if (wr_ctrl)
    begin
      if (pe)
        ctrl_d = {2'h0, wbyte_q[5:0]};
      else
        ctrl_d[CTL_PERIPHERAL_ON] = wbyte_q[CTL_PERIPHERAL_ON];
    end
    if (EV_START_DONE)
      ctrl_d[CTL_START] = 1'b0;
    if (master && stop_det)
      ctrl_d[CTL_STOP] = 1'b0;
    if (!ctrl_d[CTL_PERIPHERAL_ON])
      ctrl_d = (ctrl_d & STOP_KEEP_MASK);
    if (wr_clk)
      clk_d = wbyte_q;
    // Mode bits change only while disabled
    if (wr_ext && !pe)
      ext_d = {5'h00, wbyte_q[2:0]};
    if (wr_data)
      data_d = wbyte_q;
    else if (EV_RX_ACK_PULSE)
      data_d = RX_DATA;
    // Repeated start is allowed while master; otherwise wait for a free bus
    gen_start_d = pe && ctrl_q[CTL_START] && !EV_START_DONE &&
                  (!s1_q[S1_BUS_BUSY] || master);
    gen_stop_d  = pe && ctrl_q[CTL_STOP];
  end

  // Bus clock divider
  always_comb
  begin
    cnt_d  = 11'h000;
    tick_d = 1'b0;
    if (pe)
    begin
      if (cnt_q >= scl_period(clk_q[CLK_FAST_SELECT], {ext_q[1:0], clk_q[6:0]}) - 11'h001)
        tick_d = 1'b1;
      else
        cnt_d = cnt_q + 11'h001;
    end
  end

  // All state registers
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      aw_have_q <= 1'b0;  w_have_q <= 1'b0;  awaddr_q <= '0;  wbyte_q <= 8'h00;
      wlane_q   <= 1'b0;  awready_q <= 1'b0; wready_q <= 1'b0; bvalid_q <= 1'b0;
      bresp_q   <= RESP_OKAY; arready_q <= 1'b0; rvalid_q <= 1'b0;
      rresp_q   <= RESP_OKAY; rdata_q <= 32'h0;
      ctrl_q    <= CONTROL_RESET; clk_q <= CLOCK_SETUP_RESET;
      ext_q     <= EXT_SETUP_RESET; data_q <= DATA_RESET;
      s1_q      <= 8'h00; s2_q <= 8'h00; sr1_seen_q <= 1'b0; saw_ack_q <= 1'b0;
      scl_prev_q <= 1'b1; sda_prev_q <= 1'b1;
      gen_start_q <= 1'b0; gen_stop_q <= 1'b0; hold_q <= 1'b0;
      tick_q    <= 1'b0; irq_q <= 1'b0; cnt_q <= 11'h000;
    end
    else
    begin
      aw_have_q <= aw_have_d; w_have_q <= w_have_d; awaddr_q <= awaddr_d;
      wbyte_q   <= wbyte_d;  wlane_q <= wlane_d;  awready_q <= awready_d;
      wready_q  <= wready_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
      arready_q <= !rvalid_q ? arready_d | !do_read : arready_d;
      rvalid_q  <= rvalid_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
      ctrl_q    <= ctrl_d;   clk_q <= clk_d; ext_q <= ext_d; data_q <= data_d;
      s1_q      <= s1_d;     s2_q <= s2_d;
      sr1_seen_q <= sr1_seen_d; saw_ack_q <= saw_ack_d;
      scl_prev_q <= SCL_IN;  sda_prev_q <= SDA_IN;
      gen_start_q <= gen_start_d; gen_stop_q <= gen_stop_d; hold_q <= hold_d;
      tick_q    <= tick_d;   irq_q <= irq_d; cnt_q <= cnt_d;
    end
  end

  // Outputs straight from flops
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign GEN_START     = gen_start_q;
  assign GEN_STOP      = gen_stop_q;
  assign SCL_HOLD_LOW  = hold_q;
  assign SCL_TICK      = tick_q;
  assign TX_DATA       = data_q;
  assign IRQ           = irq_q;

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_sr2_read;
    do_read && idx_is(S_AXI_ARADDR, IDX_STATUS_TWO);
  endsequence
  sequence s_misplaced_start;
    pe && start_det && IN_BYTE;
  endsequence

  property p_busy_start;
    start_det |=> s1_q[S1_BUS_BUSY];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set on start");
  property p_hold_bd;
    s1_q[S1_BYTE_DONE] |-> SCL_HOLD_LOW;
  endproperty
  a_hold_bd: assert property (p_hold_bd) else $error("clock not held on byte done");
  property p_sr2_top;
    s_sr2_read |=> S_AXI_RVALID && S_AXI_RDATA[7:6] == 2'h0;
  endproperty
  a_sr2_top: assert property (p_sr2_top) else $error("status two top bits set");
  property p_disable;
    !pe |=> (s2_q == 8'h00) && !s1_q[S1_EVENT_PENDING] && !SCL_HOLD_LOW ##1 !IRQ;
  endproperty
  a_disable: assert property (p_disable) else $error("flags survive disable");
  property p_summary;
    (s1_q[S1_BYTE_DONE] || s2_q[S2_ACK_MISSING]) |-> s1_q[S1_EVENT_PENDING];
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag missing");
  property p_master_stop;
    pe && stop_det |=> !s1_q[S1_MASTER_ACTIVE];
  endproperty
  a_master_stop: assert property (p_master_stop) else $error("master survives stop");
  property p_misplaced;
    s_misplaced_start |=> s2_q[S2_MISPLACED] && s2_q[S2_ARB_LOST];
  endproperty
  a_misplaced: assert property (p_misplaced) else $error("misplaced start missed");
  property p_irq_gate;
    !ctrl_q[CTL_INTERRUPT_ALLOW] |=> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while not allowed");
  property p_start_free;
    pe && s1_q[S1_BUS_BUSY] && !master |=> !GEN_START;
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on busy bus");
  property p_tick_gap;
    SCL_TICK |=> !SCL_TICK [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divider period too short");
endmodule : bsf_flags
`default_nettype wire

//--- bsf_bus_model.sv
// Model of another party on the two-wire bus making start and stop conditions
`timescale 1ns/1ps
`default_nettype none
module bsf_bus_model (
  // Clock and bus lines
  input  wire logic clk,
  output var  logic scl,
  output var  logic sda
);
  // Lines idle high through their pull-ups
  initial scl = 1'b1;
  initial sda = 1'b1;
  // Start: data falls while clock high, then clock parks low
  task automatic start_cond;
    @(posedge clk) sda <= 1'b0;
    @(posedge clk) scl <= 1'b0;
  endtask : start_cond
  // Stop: clock rises first, data rises last
  task automatic stop_cond;
    @(posedge clk) sda <= 1'b0;
    @(posedge clk) scl <= 1'b1;
    @(posedge clk) sda <= 1'b1;
  endtask : stop_cond
endmodule : bsf_bus_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the status and event-flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bsf_pkg::*;
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        awr, wrdy, bv, arr, rv, gen_start, hold, irq, scl, sda;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  txd, b, e;
  logic [7:0]  rxd = '0;
  logic [8:0]  evs = '0;
  logic        irq_seen = 1'b0;
  logic        inb = 1'b0;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  // 40 MHz system clock
  initial forever #12.5 clk = ~clk;
  bsf_flags u_dut (
    .CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .SCL_IN(scl), .SDA_IN(sda), .EV_START_DONE(evs[0]), .EV_HEADER_SENT(evs[1]),
    .EV_TX_ACK_PULSE(evs[2]), .EV_RX_ACK_PULSE(evs[3]), .EV_OWN_MATCH(evs[4]),
    .EV_BROADCAST_MATCH(evs[5]), .EV_ADDR_ACKED(evs[6]), .EV_NO_ACK(evs[7]),
    .EV_ARB_LOST(evs[8]), .IN_BYTE(inb), .ACK_PULSE(1'b0), .RX_DATA(rxd),
    .DMA_BUSY(1'b0), .DMA_DONE(1'b0), .GEN_START(gen_start), .GEN_STOP(),
    .SCL_HOLD_LOW(hold), .SCL_TICK(), .TX_DATA(txd), .IRQ(irq));
  bsf_bus_model u_bus (.clk(clk), .scl(scl), .sda(sda));
  // Catch the one-cycle interrupt pulse
  always @(posedge clk) if (irq) irq_seen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Bus write; each channel released once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (!bv);
    bready <= 1'b0;
  endtask : wr
  // Bus read; answer taken at the edge that sees it
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rready <= 1'b0;
    d = rdata[7:0];
    r = rresp;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    logic [1:0] r;
    rd(a, b, r);
    chk(b, x);
  endtask : rc
  // One-cycle engine event, then let the flags settle
  task automatic ev(input int i);
    @(posedge clk);
    evs <= 9'(9'h1 << i);
    @(posedge clk);
    evs <= '0;
    repeat (2) @(posedge clk);
  endtask : ev
  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    logic [1:0] r;
    int         k;
    k = $urandom(85658);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Reset values and an unmapped address
    rc(12'h3c8, 8'h00);
    rc(12'h3cc, 8'h00);
    rd(12'h3f0, b, r);
    chk(r, RESP_SLVERR);
    // Bus watch runs while switched off
    u_bus.start_cond();
    rc(12'h3c4, 8'h10);
    u_bus.stop_cond();
    rc(12'h3c4, 8'h00);
    // First write only switches on
    wr(12'h3c0, 8'h25);
    wr(12'h3c0, 8'h2d);
    k = 0;
    while (gen_start !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    chk(gen_start, 1'b1);
    u_bus.start_cond();
    irq_seen <= 1'b0;
    ev(0);
    chk(hold, 1'b1);
    chk(irq_seen, 1'b1);
    rc(12'h3c4, 8'h93);
    e = 8'($urandom);
    wr(12'h3d8, e);
    chk(txd, e);
    rc(12'h3c4, 8'h12);
    // Transmit byte finished stretches the clock
    ev(2);
    chk(hold, 1'b1);
    rc(12'h3c4, 8'hba);
    wr(12'h3d8, e);
    rc(12'h3c4, 8'h12);
    // Status two events in random order, cleared by their read
    repeat (6)
    begin
      k = $urandom_range(1, 0);
      ev(k ? 7 : 6);
      chk(hold, k ? 1'b0 : 1'b1);
      rc(12'h3c4, 8'h92);
      rc(12'h3c8, k ? 8'h10 : 8'h20);
      rc(12'h3c8, 8'h00);
      rc(12'h3c4, 8'h12);
    end
    // Lost arbitration falls back to slave
    ev(8);
    rc(12'h3c4, 8'h90);
    rc(12'h3c8, 8'h04);
    // Slave side: address hit, received byte, stop, misplaced start
    rxd <= 8'($urandom);
    ev(4);
    rc(12'h3c4, 8'h94);
    rc(12'h3c4, 8'h10);
    ev(3);
    rc(12'h3c4, 8'h98);
    rc(12'h3d8, rxd);
    rc(12'h3c4, 8'h10);
    u_bus.stop_cond();
    rc(12'h3c8, 8'h08);
    inb <= 1'b1;
    u_bus.start_cond();
    inb <= 1'b0;
    rc(12'h3c8, 8'h06);
    e = 8'($urandom);
    wr(12'h3cc, e);
    chk(bresp, RESP_OKAY);
    rc(12'h3cc, e);
    // Switching off clears control except the stop bit, and the event flags; bus busy waits for a stop
    ev(7);
    wr(12'h3c0, 8'h00);
    rc(12'h3c8, 8'h00);
    rc(12'h3c0, 8'h00);
    u_bus.stop_cond();
    rc(12'h3c4, 8'h00);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
